// ===== hw/mba_arbiter.sv
`timescale 1ns/100ps
`default_nettype none
`include "mba_defines.svh"
module mba_arbiter #(
  parameter logic [8:0] FLASH_KB = `MBA_FLASH_KB_DEF
) (
  input wire logic CLOCK,
  input wire logic NRST,
  input wire logic SFR_WE,
  input wire logic SFR_RE,
  input wire logic [7:0] SFR_ADDR,
  input wire logic [7:0] SFR_WDATA,
  output logic [7:0] SFR_RDATA,
  input wire logic CPU_REQ,
  input wire logic CPU_CODE,
  input wire logic CPU_INDIRECT,
  input wire logic [15:0] CPU_ADDR,
  input wire logic [7:0] CPU_PTR,
  input wire logic CPU_CORE_SFR,
  input wire logic DMA_REQ,
  input wire logic [15:0] DMA_ADDR,
  output logic CPU_STALL,
  output logic DMA_STALL,
  output logic [2:0] CPU_TARGET,
  output logic [17:0] CPU_PHYS_ADDR,
  output logic [2:0] DMA_TARGET,
  output logic [17:0] DMA_PHYS_ADDR,
  output logic [7:0] PAGE_OUT,
  output logic [2:0] CBANK_OUT,
  output logic [2:0] XBANK_OUT,
  output logic OVERLAY_OUT
);
  // ----------------------------------------
  // Control registers
  // ----------------------------------------
  logic [7:0] xdata_page_select_reg;
  logic [2:0] code_bank_reg;
  logic [2:0] xdata_flash_bank_reg;
  logic sram_code_overlay_reg;
  mba_pkg::mba_owner_t last_owner_reg;

  // Highest legal bank number for this flash size
  function automatic logic [2:0] max_bank(input logic [8:0] kb);
    if (kb >= 9'h100)
      max_bank = 3'h7;
    else if (kb >= 9'h080)
      max_bank = 3'h3;
    else if (kb >= 9'h040)
      max_bank = 3'h1;
    else
      max_bank = 3'h0;
  endfunction

  // Map an external-data address onto physical memory
  function automatic logic [20:0] map_xdata(input logic [15:0] a, input logic [2:0] bank);
    logic [2:0] t;
    logic [17:0] p;
    t = mba_pkg::MEM_NONE;
    p = 18'h0;
    if (a >= `MBA_BANK_BASE)
    begin
      t = mba_pkg::MEM_FLASH;
      p = {bank, a[14:0]};
    end
    else if ({1'b0, a} < `MBA_SRAM_SIZE)
    begin
      t = mba_pkg::MEM_SRAM;
      p = {2'b00, a};
    end
    else if (a[15:7] == `MBA_SFR_MIRROR_HI)
    begin
      t = mba_pkg::MEM_SFR;
      p = {10'h0, 1'b1, a[6:0]};
    end
    map_xdata = {t, p};
  endfunction

  // ----------------------------------------
  // Register writes
  // ----------------------------------------
  // Page select, full byte
  always_ff @(posedge CLOCK or negedge NRST)
  begin
    if (!NRST)
      xdata_page_select_reg <= `MBA_RST_PAGE;
    else if (SFR_WE && SFR_ADDR == `MBA_OFF_PAGE)
      xdata_page_select_reg <= SFR_WDATA;
  end

  // Code bank; illegal values dropped, so 32 KB parts never change
  always_ff @(posedge CLOCK or negedge NRST)
  begin
    if (!NRST)
      code_bank_reg <= `MBA_RST_CBANK;
    else if (SFR_WE && SFR_ADDR == `MBA_OFF_CBANK && FLASH_KB > 9'h020
             && SFR_WDATA[2:0] <= max_bank(FLASH_KB))
      code_bank_reg <= SFR_WDATA[2:0];
  end

  // Memory control: overlay bit and xdata bank
  always_ff @(posedge CLOCK or negedge NRST)
  begin
    if (!NRST)
    begin
      sram_code_overlay_reg <= 1'b0;
      xdata_flash_bank_reg <= `MBA_RST_XBANK;
    end
    else if (SFR_WE && SFR_ADDR == `MBA_OFF_MCTL)
    begin
      sram_code_overlay_reg <= SFR_WDATA[`MBA_BIT_OVERLAY];
      if (SFR_WDATA[2:0] <= max_bank(FLASH_KB))
        xdata_flash_bank_reg <= SFR_WDATA[2:0];
    end
  end

  // Read back; reserved bits zero
  always_ff @(posedge CLOCK or negedge NRST)
  begin
    if (!NRST)
      SFR_RDATA <= 8'h00;
    else if (SFR_RE && SFR_ADDR == `MBA_OFF_PAGE)
      SFR_RDATA <= xdata_page_select_reg;
    else if (SFR_RE && SFR_ADDR == `MBA_OFF_CBANK)
      SFR_RDATA <= {5'h00, code_bank_reg};
    else if (SFR_RE && SFR_ADDR == `MBA_OFF_MCTL)
      SFR_RDATA <= {4'h0, sram_code_overlay_reg, xdata_flash_bank_reg};
    else
      SFR_RDATA <= 8'h00;
  end

  // ----------------------------------------
  // Address decode and arbitration
  // ----------------------------------------
  logic [15:0] cpu_eff_addr;
  logic [20:0] cpu_map;
  logic [20:0] dma_map;
  logic cpu_needs;
  logic dma_needs;
  logic conflict;

  // Effective CPU address and physical mapping
  always_comb
  begin
    cpu_eff_addr = CPU_INDIRECT ? {xdata_page_select_reg, CPU_PTR} : CPU_ADDR;
    cpu_map = {mba_pkg::MEM_NONE, 18'h0};
    if (CPU_CORE_SFR)
      cpu_map = {mba_pkg::MEM_NONE, 18'h0};
    else if (CPU_CODE)
    begin
      if (!CPU_ADDR[15])
        cpu_map = {mba_pkg::MEM_FLASH, 3'h0, CPU_ADDR[14:0]};
      else if (sram_code_overlay_reg && {2'b00, CPU_ADDR[14:0]} < `MBA_SRAM_SIZE)
        cpu_map = {mba_pkg::MEM_SRAM, 3'h0, CPU_ADDR[14:0]};
      else if (FLASH_KB <= 9'h020)
        cpu_map = {mba_pkg::MEM_ZERO, 18'h0};
      else
        cpu_map = {mba_pkg::MEM_FLASH, code_bank_reg, CPU_ADDR[14:0]};
    end
    else
      cpu_map = map_xdata(cpu_eff_addr, xdata_flash_bank_reg);
    dma_map = map_xdata(DMA_ADDR, xdata_flash_bank_reg);
    cpu_needs = CPU_REQ && cpu_map[20:18] != mba_pkg::MEM_NONE && cpu_map[20:18] != mba_pkg::MEM_ZERO;
    dma_needs = DMA_REQ && dma_map[20:18] != mba_pkg::MEM_NONE;
    conflict = cpu_needs && dma_needs && cpu_map[20:18] == dma_map[20:18];
  end

  // Round-robin owner; loser is stalled while both want the same memory
  always_ff @(posedge CLOCK or negedge NRST)
  begin
    if (!NRST)
    begin
      last_owner_reg <= mba_pkg::OWN_IDLE;
      CPU_STALL <= 1'b0;
      DMA_STALL <= 1'b0;
    end
    else
    begin
      CPU_STALL <= conflict && last_owner_reg == mba_pkg::OWN_CPU;
      DMA_STALL <= conflict && last_owner_reg != mba_pkg::OWN_CPU;
      if (conflict)
        last_owner_reg <= (last_owner_reg == mba_pkg::OWN_CPU) ? mba_pkg::OWN_DMA : mba_pkg::OWN_CPU;
    end
  end

  // Registered routing outputs
  always_ff @(posedge CLOCK or negedge NRST)
  begin
    if (!NRST)
    begin
      CPU_TARGET <= 3'h0;
      CPU_PHYS_ADDR <= 18'h0;
      DMA_TARGET <= 3'h0;
      DMA_PHYS_ADDR <= 18'h0;
    end
    else
    begin
      CPU_TARGET <= CPU_REQ ? cpu_map[20:18] : 3'h0;
      CPU_PHYS_ADDR <= cpu_map[17:0];
      DMA_TARGET <= DMA_REQ ? dma_map[20:18] : 3'h0;
      DMA_PHYS_ADDR <= dma_map[17:0];
    end
  end

  // Mirror of control state
  always_ff @(posedge CLOCK or negedge NRST)
  begin
    if (!NRST)
    begin
      PAGE_OUT <= 8'h00;
      CBANK_OUT <= 3'h0;
      XBANK_OUT <= 3'h0;
      OVERLAY_OUT <= 1'b0;
    end
    else
    begin
      PAGE_OUT <= xdata_page_select_reg;
      CBANK_OUT <= code_bank_reg;
      XBANK_OUT <= xdata_flash_bank_reg;
      OVERLAY_OUT <= sram_code_overlay_reg;
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  a_page_form: assert property (@(posedge CLOCK) disable iff (!NRST)
    (CPU_REQ && !CPU_CODE && !CPU_CORE_SFR && CPU_INDIRECT && cpu_eff_addr < `MBA_BANK_BASE
     && {1'b0, cpu_eff_addr} < `MBA_SRAM_SIZE) |=> CPU_PHYS_ADDR[15:8] == $past(xdata_page_select_reg))
    else $error("page byte not used");
  a_core_sfr_hidden: assert property (@(posedge CLOCK) disable iff (!NRST)
    (CPU_REQ && CPU_CORE_SFR) |=> CPU_TARGET == mba_pkg::MEM_NONE)
    else $error("core register routed");
  a_stall_one: assert property (@(posedge CLOCK) disable iff (!NRST)
    conflict |=> (CPU_STALL ^ DMA_STALL))
    else $error("conflict not resolved");
  a_low_code: assert property (@(posedge CLOCK) disable iff (!NRST)
    (CPU_REQ && CPU_CODE && !CPU_CORE_SFR && !CPU_ADDR[15]) |=> CPU_TARGET == mba_pkg::MEM_FLASH
    && CPU_PHYS_ADDR[17:15] == 3'h0)
    else $error("low code not bank 0");
  a_xbank_hold: assert property (@(posedge CLOCK) disable iff (!NRST)
    (SFR_WE && SFR_ADDR == `MBA_OFF_MCTL && SFR_WDATA[2:0] > max_bank(FLASH_KB))
    |=> $stable(xdata_flash_bank_reg))
    else $error("bad bank accepted");
  a_cbank_hold: assert property (@(posedge CLOCK) disable iff (!NRST)
    (SFR_WE && SFR_ADDR == `MBA_OFF_CBANK && SFR_WDATA[2:0] > max_bank(FLASH_KB))
    |=> $stable(code_bank_reg))
    else $error("bad code bank accepted");
  a_overlay_map: assert property (@(posedge CLOCK) disable iff (!NRST)
    (CPU_REQ && CPU_CODE && !CPU_CORE_SFR && CPU_ADDR == `MBA_BANK_BASE && sram_code_overlay_reg)
    |=> CPU_TARGET == mba_pkg::MEM_SRAM && CPU_PHYS_ADDR == 18'h0)
    else $error("overlay not applied");
  a_reserved_zero: assert property (@(posedge CLOCK) disable iff (!NRST)
    (SFR_RE && SFR_ADDR == `MBA_OFF_MCTL) |=> SFR_RDATA[7:4] == 4'h0)
    else $error("reserved bits set");
  c_conflict: cover property (@(posedge CLOCK) disable iff (!NRST) conflict ##1 conflict);
  c_overlay: cover property (@(posedge CLOCK) disable iff (!NRST) sram_code_overlay_reg && CPU_CODE);
  c_mirror: cover property (@(posedge CLOCK) disable iff (!NRST) DMA_TARGET == mba_pkg::MEM_SFR);
endmodule // mba_arbiter
`default_nettype wire

// ===== hw/mba_defines.svh
`ifndef MBA_DEFINES_SVH
`define MBA_DEFINES_SVH
// ----------------------------------------
// Register offsets and resets
// ----------------------------------------
`define MBA_OFF_PAGE 8'h93
`define MBA_OFF_CBANK 8'h9F
`define MBA_OFF_MCTL 8'hC7
`define MBA_RST_PAGE 8'h00
`define MBA_RST_CBANK 3'h1
`define MBA_RST_XBANK 3'h0
`define MBA_BIT_OVERLAY 3
// ----------------------------------------
// Address map
// ----------------------------------------
`define MBA_BANK_BASE 16'h8000
`define MBA_SFR_MIRROR_HI 9'h0E1
`define MBA_SRAM_SIZE 17'h02000
`define MBA_FLASH_KB_DEF 9'h100
`endif

// ===== hw/mba_pkg.sv
package mba_pkg;
  // Which physical memory an access lands on
  typedef enum logic [2:0] {MEM_NONE, MEM_FLASH, MEM_SRAM, MEM_SFR, MEM_ZERO} mba_target_t;
  // Grant owner of the shared memory
  typedef enum logic [1:0] {OWN_IDLE, OWN_CPU, OWN_DMA} mba_owner_t;
endpackage

// ===== testbench/mba_bus_masters.sv
`timescale 1ns/100ps
`default_nettype none
// --------------------------------
// CPU and DMA request model
// --------------------------------
module mba_bus_masters (
  input wire logic clock,
  output logic cpu_req,
  output logic cpu_code,
  output logic cpu_indirect,
  output logic [15:0] cpu_addr,
  output logic [7:0] cpu_ptr,
  output logic cpu_core_sfr,
  output logic dma_req,
  output logic [15:0] dma_addr
);
  // Quiet masters from time zero
  initial
  begin
    {cpu_req, cpu_code, cpu_indirect, cpu_core_sfr, dma_req} = 5'h00;
    cpu_addr = 16'h0000;
    cpu_ptr = 8'h00;
    dma_addr = 16'h0000;
  end

  // One request slot; released lines flip so stale values never look valid
  task automatic access(input logic cr, cc, ci, input logic [15:0] ca, input logic [7:0] cp,
    input logic ck, dr, input logic [15:0] da);
    @(negedge clock);
    {cpu_req, cpu_code, cpu_indirect, cpu_core_sfr, dma_req} = {cr, cc, ci, ck, dr};
    cpu_addr = ca;
    cpu_ptr = cp;
    dma_addr = da;
    @(negedge clock);
    cpu_req = 1'b0;
    dma_req = 1'b0;
    cpu_addr = ~cpu_addr;
    cpu_ptr = ~cpu_ptr;
    dma_addr = ~dma_addr;
  endtask
endmodule // mba_bus_masters
`default_nettype wire

// ===== testbench/tb_memory_bank_mapping_arbiter.sv
`timescale 1ns/100ps
`default_nettype none
module tb_memory_bank_mapping_arbiter;
  logic CLOCK, NRST, SFR_WE, SFR_RE, CPU_REQ, CPU_CODE, CPU_INDIRECT, CPU_CORE_SFR, DMA_REQ;
  logic CPU_STALL, DMA_STALL, OVERLAY_OUT;
  logic [7:0] SFR_ADDR, SFR_WDATA, SFR_RDATA, CPU_PTR, PAGE_OUT;
  logic [15:0] CPU_ADDR, DMA_ADDR;
  logic [2:0] CPU_TARGET, DMA_TARGET, CBANK_OUT, XBANK_OUT;
  logic [17:0] CPU_PHYS_ADDR, DMA_PHYS_ADDR;
  logic [2:0] SMALL_CPU_TARGET;
  logic [7:0] SMALL_SFR_RDATA;
  int err_count = 0;
  int tests_run = 0;

  // 64 KB part so that bank refusals can be seen
  mba_arbiter #(.FLASH_KB(9'h040)) dut_u (.CLOCK(CLOCK), .NRST(NRST), .SFR_WE(SFR_WE),
    .SFR_RE(SFR_RE), .SFR_ADDR(SFR_ADDR), .SFR_WDATA(SFR_WDATA), .SFR_RDATA(SFR_RDATA),
    .CPU_REQ(CPU_REQ), .CPU_CODE(CPU_CODE), .CPU_INDIRECT(CPU_INDIRECT), .CPU_ADDR(CPU_ADDR),
    .CPU_PTR(CPU_PTR), .CPU_CORE_SFR(CPU_CORE_SFR), .DMA_REQ(DMA_REQ), .DMA_ADDR(DMA_ADDR),
    .CPU_STALL(CPU_STALL), .DMA_STALL(DMA_STALL), .CPU_TARGET(CPU_TARGET),
    .CPU_PHYS_ADDR(CPU_PHYS_ADDR), .DMA_TARGET(DMA_TARGET), .DMA_PHYS_ADDR(DMA_PHYS_ADDR),
    .PAGE_OUT(PAGE_OUT), .CBANK_OUT(CBANK_OUT), .XBANK_OUT(XBANK_OUT),
    .OVERLAY_OUT(OVERLAY_OUT));
  mba_bus_masters m_u (.clock(CLOCK), .cpu_req(CPU_REQ), .cpu_code(CPU_CODE),
    .cpu_indirect(CPU_INDIRECT), .cpu_addr(CPU_ADDR), .cpu_ptr(CPU_PTR),
    .cpu_core_sfr(CPU_CORE_SFR), .dma_req(DMA_REQ), .dma_addr(DMA_ADDR));
  // 32 KB part on the same stimulus, so the empty code bank area gets exercised
  mba_arbiter #(.FLASH_KB(9'h020)) dut_small_u (.CLOCK(CLOCK), .NRST(NRST), .SFR_WE(SFR_WE),
    .SFR_RE(SFR_RE), .SFR_ADDR(SFR_ADDR), .SFR_WDATA(SFR_WDATA), .SFR_RDATA(SMALL_SFR_RDATA),
    .CPU_REQ(CPU_REQ), .CPU_CODE(CPU_CODE), .CPU_INDIRECT(CPU_INDIRECT), .CPU_ADDR(CPU_ADDR),
    .CPU_PTR(CPU_PTR), .CPU_CORE_SFR(CPU_CORE_SFR), .DMA_REQ(DMA_REQ), .DMA_ADDR(DMA_ADDR),
    .CPU_STALL(), .DMA_STALL(), .CPU_TARGET(SMALL_CPU_TARGET), .CPU_PHYS_ADDR(),
    .DMA_TARGET(), .DMA_PHYS_ADDR(), .PAGE_OUT(), .CBANK_OUT(), .XBANK_OUT(), .OVERLAY_OUT());

  // --------------------------------
  // Shared helpers
  // --------------------------------
  task automatic chk(input string what, input logic [17:0] exp, input logic [17:0] got);
    tests_run++;
    if (got !== exp)
    begin
      $display("Error %s expected %h seen %h", what, exp, got);
      err_count++;
    end
  endtask

  task automatic sfr_wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge CLOCK);
    {SFR_WE, SFR_ADDR, SFR_WDATA} = {1'b1, a, d};
    @(negedge CLOCK);
    SFR_WE = 1'b0;
  endtask

  // Read data is registered, so it is taken one edge after the strobe
  task automatic sfr_chk(input logic [7:0] a, input logic [7:0] exp);
    @(negedge CLOCK);
    {SFR_RE, SFR_ADDR} = {1'b1, a};
    @(negedge CLOCK);
    SFR_RE = 1'b0;
    chk("sfr_rdata", {10'h000, exp}, {10'h000, SFR_RDATA});
  endtask

  task automatic cpu(input logic c, i, input logic [15:0] a, input logic [7:0] p,
    input logic k, input logic [2:0] t, input logic [17:0] pa);
    m_u.access(1'b1, c, i, a, p, k, 1'b0, 16'h0000);
    chk("cpu_target", {15'h0000, t}, {15'h0000, CPU_TARGET});
    if (t != mba_pkg::MEM_NONE)
      chk("cpu_phys", pa, CPU_PHYS_ADDR);
  endtask

  // --------------------------------
  // Scenarios
  // --------------------------------
  task automatic test_reset;
    sfr_chk(8'h93, 8'h00);
    sfr_chk(8'h9F, 8'h01);
    sfr_chk(8'hC7, 8'h00);
    chk("cbank_out", 18'h00001, {15'h0000, CBANK_OUT});
    $display("test_reset done");
  endtask

  task automatic test_page;
    sfr_wr(8'h93, 8'h12);
    sfr_chk(8'h93, 8'h12);
    chk("page_out", 18'h00012, {10'h000, PAGE_OUT});
    cpu(1'b0, 1'b1, 16'hFFFF, 8'hAB, 1'b0, mba_pkg::MEM_SRAM, 18'h012AB);
    sfr_wr(8'h93, 8'hFF);
    sfr_chk(8'h93, 8'hFF);
    cpu(1'b0, 1'b1, 16'h0000, 8'h10, 1'b0, mba_pkg::MEM_FLASH, 18'h07F10);
    $display("test_page done");
  endtask

  // Bad bank values are dropped while the overlay bit still follows the write
  task automatic test_banks;
    sfr_wr(8'hC7, 8'h09);
    sfr_chk(8'hC7, 8'h09);
    sfr_wr(8'hC7, 8'h05);
    sfr_chk(8'hC7, 8'h01);
    sfr_wr(8'hC7, 8'hFA);
    sfr_chk(8'hC7, 8'h09);
    sfr_wr(8'h9F, 8'h00);
    sfr_chk(8'h9F, 8'h00);
    chk("small_cbank", 18'h00001, {10'h000, SMALL_SFR_RDATA});
    sfr_wr(8'h9F, 8'h03);
    sfr_chk(8'h9F, 8'h00);
    sfr_wr(8'h9F, 8'hF9);
    sfr_chk(8'h9F, 8'h01);
    chk("xbank_ovl", 18'h00003, {14'h0000, XBANK_OUT, OVERLAY_OUT});
    $display("test_banks done");
  endtask

  task automatic test_map;
    cpu(1'b1, 1'b0, 16'h1234, 8'h00, 1'b0, mba_pkg::MEM_FLASH, 18'h01234);
    cpu(1'b1, 1'b0, 16'h9FFF, 8'h00, 1'b0, mba_pkg::MEM_SRAM, 18'h01FFF);
    cpu(1'b1, 1'b0, 16'hA000, 8'h00, 1'b0, mba_pkg::MEM_FLASH, 18'h0A000);
    chk("small_zero", {15'h0000, mba_pkg::MEM_ZERO}, {15'h0000, SMALL_CPU_TARGET});
    cpu(1'b0, 1'b0, 16'h8004, 8'h00, 1'b0, mba_pkg::MEM_FLASH, 18'h08004);
    cpu(1'b0, 1'b0, 16'h7080, 8'h00, 1'b0, mba_pkg::MEM_SFR, 18'h00080);
    cpu(1'b0, 1'b0, 16'h70A0, 8'h00, 1'b0, mba_pkg::MEM_SFR, 18'h000A0);
    cpu(1'b0, 1'b0, 16'h70C5, 8'h00, 1'b0, mba_pkg::MEM_SFR, 18'h000C5);
    cpu(1'b0, 1'b0, 16'h70E0, 8'h00, 1'b1, mba_pkg::MEM_NONE, 18'h00000);
    $display("test_map done");
  endtask

  // Same memory twice: the loser alternates; other memories never stall
  task automatic test_conflict;
    m_u.access(1'b1, 1'b0, 1'b0, 16'h0100, 8'h00, 1'b0, 1'b1, 16'h0200);
    chk("stall_1", 18'h00001, {16'h0000, CPU_STALL, DMA_STALL});
    chk("dma_target_1", {15'h0000, mba_pkg::MEM_SRAM}, {15'h0000, DMA_TARGET});
    chk("dma_phys_1", 18'h00200, DMA_PHYS_ADDR);
    m_u.access(1'b1, 1'b0, 1'b0, 16'h0100, 8'h00, 1'b0, 1'b1, 16'h0200);
    chk("stall_2", 18'h00002, {16'h0000, CPU_STALL, DMA_STALL});
    m_u.access(1'b1, 1'b1, 1'b0, 16'h0100, 8'h00, 1'b0, 1'b1, 16'h0200);
    chk("stall_3", 18'h00000, {16'h0000, CPU_STALL, DMA_STALL});
    m_u.access(1'b1, 1'b0, 1'b0, 16'h0100, 8'h00, 1'b1, 1'b1, 16'h0200);
    chk("stall_4", 18'h00000, {16'h0000, CPU_STALL, DMA_STALL});
    // DMA alone into the mirrored port register
    m_u.access(1'b0, 1'b0, 1'b0, 16'h0000, 8'h00, 1'b0, 1'b1, 16'h7090);
    chk("dma_target_2", {15'h0000, mba_pkg::MEM_SFR}, {15'h0000, DMA_TARGET});
    chk("dma_phys_2", 18'h00090, DMA_PHYS_ADDR);
    $display("test_conflict done");
  endtask

  task automatic stop_test;
    $display("Comparisons %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // 20 MHz clock
  initial
  begin
    CLOCK = 1'b0;
    forever #25 CLOCK = ~CLOCK;
  end

  // Whole run is about 75 cycles; a hang is cut at 1000
  initial
  begin
    #50000;
    err_count++;
    stop_test();
  end

  // Main sequence, reset held five cycles
  initial
  begin
    {NRST, SFR_WE, SFR_RE, SFR_ADDR, SFR_WDATA} = 19'h00000;
    repeat (5) @(negedge CLOCK);
    NRST = 1'b1;
    test_reset();
    test_page();
    test_banks();
    test_map();
    test_conflict();
    stop_test();
  end
endmodule // tb_memory_bank_mapping_arbiter
`default_nettype wire
